/* File: devstat_pkg.sv */
package devstat_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  // the status word sits at an odd-of-four offset, so offsets are indices
  localparam logic [7:0] DEV_CTL_IDX = 8'h48;
  localparam logic [7:0] DEV_STS_IDX = 8'h4a;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int WORD_W = 16;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int RRL_LSB = 12;
  localparam int RRL_MSB = 14;
  localparam int FRI_BIT = 15;
  localparam logic [2:0] RRL_RESET = 3'h2;
  localparam logic [2:0] RRL_MAX_CODE = 3'h5;
  localparam logic [2:0] RRL_128 = 3'h0;
  localparam logic [11:0] CTL_LOW_RESET = 12'h000;

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int CES_BIT = 0;
  localparam int NFS_BIT = 1;
  localparam int FES_BIT = 2;
  localparam int URS_BIT = 3;
  localparam int AUX_BIT = 4;
  localparam int TXP_BIT = 5;
  localparam int NUM_FLAGS = 4;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

endpackage

/* File: w1c_flag.sv */
`timescale 1ns/100ps
`default_nettype none
module w1c_flag (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic set_pulse,
  input wire logic clr_pulse,
  output logic flag
);
  // set wins over a same-cycle clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (set_pulse) begin
      flag <= 1'b1;
    end else if (clr_pulse) begin
      flag <= 1'b0;
    end
  end

  AST_SET_WINS: assert property (@(posedge clk_sys) disable iff (rst)
    set_pulse |=> flag)
    else $error("flag lost on set");
  AST_CLR_ONLY: assert property (@(posedge clk_sys) disable iff (rst)
    clr_pulse && !set_pulse |=> !flag)
    else $error("flag not cleared");
endmodule
`default_nettype wire

/* File: rrl_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module rrl_decode
  import devstat_pkg::*;
(
  input wire logic [2:0] code,
  output logic [2:0] eff_code
);
  // reserved codes act as the smallest limit
  assign eff_code = (code > RRL_MAX_CODE) ? RRL_128 : code;
endmodule
`default_nettype wire

/* File: devstat_regs.sv */
// Operation
// - read request limit at control bits 14:12, reset 2, codes 0-5 mean 128-4096 bytes.
// - reserved limit codes 6 and 7 are taken as a 128 byte limit.
// - the limit is storage only and changes no forwarding.
// - control bit 15, function reset initiate, is read-only zero.
// - status bit 0 sets on correctable error, resets 0, write 1 clears.
// - status bit 1 sets on non-fatal error, resets 0, write 1 clears.
// - status bit 2 sets on fatal error, resets 0, write 1 clears.
// - status bit 3 sets on unsupported request, resets 0, write 1 clears.
// - the error flags latch regardless of reporting enables.
// - status bit 4, aux power seen, reads zero always.
// - status bit 5, transactions pending, reads zero always.
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/100ps
`default_nettype none
module devstat_regs
  import devstat_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic corr_err_det,
  input wire logic nonfatal_err_det,
  input wire logic fatal_err_det,
  input wire logic unsupp_req_det,
  output logic [2:0] read_request_limit,
  output logic [2:0] read_request_limit_eff,
  output logic [3:0] err_flags
);

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire logic req;
  wire logic [7:0] word_idx;
  wire logic hit_ctl;
  wire logic hit_sts;
  wire logic hit_any;
  wire logic wr_ctl;
  wire logic wr_sts;
  wire logic [DATA_W-1:0] rd_data;
  wire logic [WORD_W-1:0] ctl_word;
  wire logic [WORD_W-1:0] sts_word;
  wire logic [NUM_FLAGS-1:0] det_vec;
  wire logic [NUM_FLAGS-1:0] clr_vec;
  wire logic [NUM_FLAGS-1:0] flag_vec;
  wire logic [2:0] eff_code;
  wire logic func_reset_initiate;
  wire logic corr_err_seen;
  wire logic nonfatal_err_seen;
  wire logic fatal_err_seen;
  wire logic unsupp_req_seen;
  wire logic aux_power_seen;
  wire logic txn_pending;
  wire logic [9:0] sts_reserved;
  wire logic [DATA_W-1:0] ctl_rd;
  wire logic [DATA_W-1:0] sts_rd;
  bus_state_t state_reg;
  bus_state_t state_next;
  logic [2:0] rrl_reg;
  logic [2:0] rrl_next;

  // registers take one word each, byte address is index times four
  assign req = wb_cyc_i && wb_stb_i && (state_reg == BUS_IDLE);
  assign word_idx = wb_adr_i[ADDR_W-1:2];
  assign hit_ctl = word_idx == DEV_CTL_IDX;
  assign hit_sts = word_idx == DEV_STS_IDX;
  assign hit_any = hit_ctl || hit_sts;
  assign wr_ctl = req && wb_we_i && hit_ctl && wb_sel_i[1];
  assign wr_sts = req && wb_we_i && hit_sts && wb_sel_i[0];

  // ----------------------------------------------------------------
  // control word
  // ----------------------------------------------------------------
  // only the limit field is held here; bit 15 has no storage
  assign rrl_next = wr_ctl ? wb_dat_i[RRL_MSB:RRL_LSB] : rrl_reg;
  assign func_reset_initiate = 1'b0;
  assign ctl_word = {func_reset_initiate, rrl_reg, CTL_LOW_RESET};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rrl_reg <= RRL_RESET;
    end else begin
      rrl_reg <= rrl_next;
    end
  end

  rrl_decode u_rrl_decode (
    .code(rrl_reg),
    .eff_code(eff_code)
  );

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  // detections feed flags straight, no enable gating
  assign det_vec = {unsupp_req_det, fatal_err_det, nonfatal_err_det, corr_err_det};
  assign clr_vec = wr_sts ? wb_dat_i[NUM_FLAGS-1:0] : FLAGS_RESET;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_FLAGS; gi++) begin : g_flag
      w1c_flag u_flag (
        .clk_sys(clk_sys),
        .rst(rst),
        .set_pulse(det_vec[gi]),
        .clr_pulse(clr_vec[gi]),
        .flag(flag_vec[gi])
      );
    end
  endgenerate

  assign corr_err_seen = flag_vec[CES_BIT];
  assign nonfatal_err_seen = flag_vec[NFS_BIT];
  assign fatal_err_seen = flag_vec[FES_BIT];
  assign unsupp_req_seen = flag_vec[URS_BIT];

  // aux power, pending and reserved bits are constant zero
  assign aux_power_seen = 1'b0;
  assign txn_pending = 1'b0;
  assign sts_reserved = 10'h000;
  assign sts_word = {sts_reserved, txn_pending, aux_power_seen, unsupp_req_seen,
                     fatal_err_seen, nonfatal_err_seen, corr_err_seen};

  // upper half of each word reads zero
  assign ctl_rd = {16'h0000, ctl_word};
  assign sts_rd = {16'h0000, sts_word};
  assign rd_data = hit_ctl ? ctl_rd :
                   hit_sts ? sts_rd : 32'h0000_0000;

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      BUS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          state_next = BUS_ACK;
        end
      end
      BUS_ACK: begin
        state_next = BUS_IDLE;
      end
      default: begin
        state_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg <= BUS_IDLE;
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      wb_ack_o <= req && hit_any;
      wb_err_o <= req && !hit_any;
      wb_dat_o <= req ? rd_data : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // limit is advisory only, no forwarding path reads it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      read_request_limit <= RRL_RESET;
      read_request_limit_eff <= RRL_RESET;
      err_flags <= FLAGS_RESET;
    end else begin
      read_request_limit <= rrl_reg;
      read_request_limit_eff <= eff_code;
      err_flags <= flag_vec;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_RRL_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
    wr_ctl |=> rrl_reg == $past(wb_dat_i[RRL_MSB:RRL_LSB]))
    else $error("limit field not written");
  AST_RRL_RESERVED: assert property (@(posedge clk_sys) disable iff (rst)
    rrl_reg > RRL_MAX_CODE |=> read_request_limit_eff == RRL_128)
    else $error("reserved limit not mapped to 128");
  AST_FRI_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack_o && $past(hit_ctl && !wb_we_i) |-> !wb_dat_o[FRI_BIT])
    else $error("function reset bit read nonzero");
  AST_CORR_SET: assert property (@(posedge clk_sys) disable iff (rst)
    corr_err_det |=> ##1 err_flags[CES_BIT])
    else $error("correctable flag not seen");
  AST_NONFATAL_SET: assert property (@(posedge clk_sys) disable iff (rst)
    nonfatal_err_det |=> flag_vec[NFS_BIT])
    else $error("nonfatal flag not set");
  AST_FATAL_SET: assert property (@(posedge clk_sys) disable iff (rst)
    fatal_err_det |=> flag_vec[FES_BIT])
    else $error("fatal flag not set");
  AST_UR_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
    wr_sts && wb_dat_i[URS_BIT] && !unsupp_req_det |=> !flag_vec[URS_BIT])
    else $error("unsupported request flag not cleared");
  AST_STS_ZEROS: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack_o && $past(hit_sts && !wb_we_i) |-> wb_dat_o[WORD_W-1:AUX_BIT] == 12'h000)
    else $error("constant status bits nonzero");
  AST_TXP_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack_o && $past(hit_sts && !wb_we_i) |-> wb_dat_o[DATA_W-1:TXP_BIT] == 27'h0)
    else $error("pending or reserved bits nonzero");
  AST_ACK_ONE: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack_o |=> !wb_ack_o && !wb_err_o)
    else $error("ack held over two cycles");

  // ----------------------------------------------------------------
  // checks: handshake
  // ----------------------------------------------------------------
  // answer state always falls back to idle, so a held request is retaken
  AST_ERR_ONE: assert property (@(posedge clk_sys) disable iff (rst)
    wb_err_o |=> !wb_err_o && !wb_ack_o)
    else $error("err held over two cycles");
  AST_ACK_ERR_EXCL: assert property (@(posedge clk_sys) disable iff (rst)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  AST_MAPPED_ACK: assert property (@(posedge clk_sys) disable iff (rst)
    req && hit_any |=> wb_ack_o)
    else $error("mapped request not acknowledged");
  AST_UNMAPPED_ERR: assert property (@(posedge clk_sys) disable iff (rst)
    req && !hit_any |=> wb_err_o)
    else $error("unmapped request not refused");
  AST_NO_SPURIOUS: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack_o || wb_err_o |-> $past(req))
    else $error("answer without request");
  AST_STATE_RETURN: assert property (@(posedge clk_sys) disable iff (rst)
    state_reg == BUS_ACK |=> state_reg == BUS_IDLE)
    else $error("handshake stuck in answer state");
  AST_STATE_ONEHOT: assert property (@(posedge clk_sys) disable iff (rst)
    $onehot(state_reg))
    else $error("handshake state not one-hot");
  AST_DAT_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  AST_UPPER_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack_o |-> wb_dat_o[DATA_W-1:WORD_W] == 16'h0000)
    else $error("upper half of word nonzero");
  AST_CTL_WRITE_ACK: assert property (@(posedge clk_sys) disable iff (rst)
    wr_ctl |=> wb_ack_o)
    else $error("control write not acknowledged");
  AST_STS_WRITE_ACK: assert property (@(posedge clk_sys) disable iff (rst)
    wr_sts |=> wb_ack_o)
    else $error("status write not acknowledged");

  // ----------------------------------------------------------------
  // checks: control word
  // ----------------------------------------------------------------
  AST_CTL_READ: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack_o && $past(hit_ctl && !wb_we_i) |->
      wb_dat_o == {16'h0000, 1'b0, $past(rrl_reg), CTL_LOW_RESET})
    else $error("control read data wrong");
  AST_RRL_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    !wr_ctl |=> $stable(rrl_reg))
    else $error("limit changed without write");
  AST_CTL_LANE: assert property (@(posedge clk_sys) disable iff (rst)
    req && wb_we_i && hit_ctl && !wb_sel_i[1] |=> $stable(rrl_reg))
    else $error("limit written without its byte lane");
  AST_READ_KEEPS: assert property (@(posedge clk_sys) disable iff (rst)
    req && !wb_we_i |=> $stable(rrl_reg))
    else $error("limit changed by a read");
  AST_UNMAPPED_KEEPS: assert property (@(posedge clk_sys) disable iff (rst)
    req && !hit_any |=> $stable(rrl_reg))
    else $error("limit changed by unmapped access");

  // ----------------------------------------------------------------
  // checks: status word
  // ----------------------------------------------------------------
  AST_CORR_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
    wr_sts && wb_dat_i[CES_BIT] && !corr_err_det |=> !flag_vec[CES_BIT])
    else $error("correctable flag not cleared");
  AST_NONFATAL_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
    wr_sts && wb_dat_i[NFS_BIT] && !nonfatal_err_det |=> !flag_vec[NFS_BIT])
    else $error("nonfatal flag not cleared");
  AST_FATAL_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
    wr_sts && wb_dat_i[FES_BIT] && !fatal_err_det |=> !flag_vec[FES_BIT])
    else $error("fatal flag not cleared");
  AST_UR_SET: assert property (@(posedge clk_sys) disable iff (rst)
    unsupp_req_det |=> flag_vec[URS_BIT])
    else $error("unsupported request flag not set");
  AST_FLAG_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    !wr_sts && det_vec == FLAGS_RESET |=> $stable(flag_vec))
    else $error("flags changed without cause");
  AST_CLEAR_MASK: assert property (@(posedge clk_sys) disable iff (rst)
    wr_sts && det_vec == FLAGS_RESET |=>
      flag_vec == ($past(flag_vec) & ~$past(wb_dat_i[NUM_FLAGS-1:0])))
    else $error("clear touched the wrong flags");
  AST_STS_READ: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack_o && $past(hit_sts && !wb_we_i) |->
      wb_dat_o[NUM_FLAGS-1:0] == $past(flag_vec))
    else $error("status read data wrong");
  AST_AUX_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    wb_ack_o && $past(hit_sts && !wb_we_i) |-> !wb_dat_o[AUX_BIT])
    else $error("aux power bit read nonzero");

  // ----------------------------------------------------------------
  // checks: outputs
  // ----------------------------------------------------------------
  AST_LIMIT_OUT: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> read_request_limit == $past(rrl_reg))
    else $error("limit output does not follow field");
  AST_EFF_PASS: assert property (@(posedge clk_sys) disable iff (rst)
    (rrl_reg <= RRL_MAX_CODE) |=> read_request_limit_eff == $past(rrl_reg))
    else $error("defined limit code altered");
  AST_EFF_RANGE: assert property (@(posedge clk_sys) disable iff (rst)
    read_request_limit_eff <= RRL_MAX_CODE)
    else $error("effective limit out of range");
  AST_FLAG_COPY: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> err_flags == $past(flag_vec))
    else $error("flag output does not follow flags");
  AST_NONFATAL_SEEN: assert property (@(posedge clk_sys) disable iff (rst)
    nonfatal_err_det |=> ##1 err_flags[NFS_BIT])
    else $error("nonfatal flag not seen");
  AST_FATAL_SEEN: assert property (@(posedge clk_sys) disable iff (rst)
    fatal_err_det |=> ##1 err_flags[FES_BIT])
    else $error("fatal flag not seen");
  AST_UR_SEEN: assert property (@(posedge clk_sys) disable iff (rst)
    unsupp_req_det |=> ##1 err_flags[URS_BIT])
    else $error("unsupported request flag not seen");

  COV_CTL_WRITE: cover property (@(posedge clk_sys) disable iff (rst) wr_ctl);
  COV_STS_CLEAR: cover property (@(posedge clk_sys) disable iff (rst)
    wr_sts && |wb_dat_i[NUM_FLAGS-1:0]);
  COV_SET_CLR: cover property (@(posedge clk_sys) disable iff (rst)
    wr_sts && wb_dat_i[CES_BIT] && corr_err_det);
  COV_UNMAPPED: cover property (@(posedge clk_sys) disable iff (rst) wb_err_o);
  COV_RESERVED_CODE: cover property (@(posedge clk_sys) disable iff (rst)
    rrl_reg > RRL_MAX_CODE);

endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import devstat_pkg::*;
  localparam logic [ADDR_W-1:0] CTL_A = {DEV_CTL_IDX, 2'b00};
  localparam logic [ADDR_W-1:0] STS_A = {DEV_STS_IDX, 2'b00};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [DATA_W-1:0] dat = '0;
  logic [3:0] det = 4'h0;
  logic [DATA_W-1:0] dat_o;
  logic ack;
  logic err;
  logic [2:0] rrl;
  logic [2:0] rrl_eff;
  logic [3:0] flags;
  logic [DATA_W-1:0] q;
  logic e;
  logic [DATA_W-1:0] d;
  int err_total = 0;
  int checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  devstat_regs DUT (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .wb_err_o(err), .corr_err_det(det[0]), .nonfatal_err_det(det[1]),
    .fatal_err_det(det[2]), .unsupp_req_det(det[3]), .read_request_limit(rrl),
    .read_request_limit_eff(rrl_eff), .err_flags(flags));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [DATA_W-1:0] exp_ctl(input logic [2:0] c);
    return {16'h0000, 1'b0, c, 12'h000};
  endfunction

  function automatic logic [2:0] exp_eff(input logic [2:0] c);
    return (c > RRL_MAX_CODE) ? RRL_128 : c;
  endfunction

  task automatic check(input string name, input logic [DATA_W-1:0] seen,
                       input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [3:0] s,
                     input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd,
                     output logic er);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= wd;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(ack === 1'b1 || err === 1'b1) && n < 20);
    rd = dat_o;
    er = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) check("bus answer", 32'h0, 32'h1);
  endtask

  task automatic pulse(input int i);
    @(posedge clk_sys);
    det[i] <= 1'b1;
    @(posedge clk_sys);
    det[i] <= 1'b0;
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #(25 * 4000);
    err_total++;
    conclude();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(66861));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, CTL_A, 4'hf, '0, q, e);
    check("ctl reset", q, exp_ctl(RRL_RESET));
    bus(1'b0, STS_A, 4'hf, '0, q, e);
    check("sts reset", q, 32'h0);
    check("limit outputs reset", {26'h0, rrl, rrl_eff}, {26'h0, RRL_RESET, RRL_RESET});
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      d = $urandom | 32'h0000_8000;
      d[14:12] = c[2:0];
      bus(1'b1, CTL_A, 4'hf, d, q, e);
      bus(1'b0, CTL_A, 4'hf, '0, q, e);
      check("ctl readback", q, exp_ctl(c[2:0]));
      check("limit stored", {29'h0, rrl}, {29'h0, c[2:0]});
      check("limit effective", {29'h0, rrl_eff}, {29'h0, exp_eff(c[2:0])});
    end
    bus(1'b1, CTL_A, 4'hd, 32'h0000_5000, q, e);
    bus(1'b0, CTL_A, 4'hf, '0, q, e);
    check("ctl lane guard", q, exp_ctl(3'h7));
    $display("test limit done");
    for (int i = 0; i < NUM_FLAGS; i++) begin
      pulse(i);
      bus(1'b0, STS_A, 4'hf, '0, q, e);
      check("flag set", q, 32'h1 << i);
      check("flag copy", {28'h0, flags}, {28'h0, 4'h1 << i});
      bus(1'b1, STS_A, 4'he, 32'hf, q, e);
      bus(1'b0, STS_A, 4'hf, '0, q, e);
      check("clear lane guard", q, 32'h1 << i);
      d = ($urandom & 32'hffff_fff0) | (32'h1 << i);
      bus(1'b1, STS_A, 4'hf, d, q, e);
      bus(1'b0, STS_A, 4'hf, '0, q, e);
      check("flag cleared", q, 32'h0);
    end
    $display("test flags done");
    pulse(2);
    // detection lands on the very edge that takes the clear
    fork
      bus(1'b1, STS_A, 4'hf, 32'h4, q, e);
      begin
        @(posedge clk_sys);
        det[2] <= 1'b1;
        @(posedge clk_sys);
        det[2] <= 1'b0;
      end
    join
    bus(1'b0, STS_A, 4'hf, '0, q, e);
    check("set beats clear", q, 32'h4);
    bus(1'b1, STS_A, 4'hf, 32'h4, q, e);
    bus(1'b0, STS_A, 4'hf, '0, q, e);
    check("late clear", q, 32'h0);
    $display("test collision done");
    bus(1'b1, 10'h000, 4'hf, 32'h0000_1000, q, e);
    check("unmapped write err", {31'h0, e}, 32'h1);
    bus(1'b0, 10'h3fc, 4'hf, '0, q, e);
    check("unmapped read err", {31'h0, e}, 32'h1);
    bus(1'b0, CTL_A, 4'hf, '0, q, e);
    check("ctl after unmapped", q, exp_ctl(3'h7));
    $display("test unmapped done");
    pulse(1);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b0, CTL_A, 4'hf, '0, q, e);
    check("ctl after reset", q, exp_ctl(RRL_RESET));
    bus(1'b0, STS_A, 4'hf, '0, q, e);
    check("sts after reset", q, 32'h0);
    check("flags after reset", {28'h0, flags}, 32'h0);
    $display("test reset again done");
    conclude();
  end
endmodule
`default_nettype wire
